// File: inc/spod_pkg.sv
// Package of constants and types for the scan port and output-disable block.
// Contract
// - Sample mode select on rising test clock.
// - Capture data input into selected register on rise.
// - Shift selected register out on falling edges.
// - Data output driven only during shifting.
// - Data output floats while output disable asserted.
// - Test reset high gives scan system control.
// - Test reset low: functional mode, scan ignored.
// - Pin B is emulator interrupt when reset high.
// - Pin A is emulator interrupt when reset high.
// - Test reset low makes pin B output disable.
// - Disable needs reset low, A high, B low.
// - Disable condition floats every output driver.
package spod_pkg;

  // ----------------------------------------------------------------
  // Widths and codes
  // ----------------------------------------------------------------
  localparam int IR_WIDTH  = 4;
  localparam int DIR_WIDTH = 2;
  localparam logic [3:0] IR_RESET_VALUE    = 4'hF;
  localparam logic [3:0] IR_CAPTURE_VALUE  = 4'h1;
  localparam logic [3:0] INSTR_EMU_DIR     = 4'h2;
  localparam logic [1:0] EMU_DIR_RESET     = 2'h0;
  localparam int DIR_BIT_A = 0;
  localparam int DIR_BIT_B = 1;

  typedef enum logic [3:0] {
    ST_RESET      = 4'h0,
    ST_IDLE       = 4'h1,
    ST_SEL_DR     = 4'h2,
    ST_CAPTURE_DR = 4'h3,
    ST_SHIFT_DR   = 4'h4,
    ST_EXIT1_DR   = 4'h5,
    ST_PAUSE_DR   = 4'h6,
    ST_EXIT2_DR   = 4'h7,
    ST_UPDATE_DR  = 4'h8,
    ST_SEL_IR     = 4'h9,
    ST_CAPTURE_IR = 4'hA,
    ST_SHIFT_IR   = 4'hB,
    ST_EXIT1_IR   = 4'hC,
    ST_PAUSE_IR   = 4'hD,
    ST_EXIT2_IR   = 4'hE,
    ST_UPDATE_IR  = 4'hF
  } spod_state_type;

  typedef struct packed {
    logic modeSelect;
    logic dataIn;
    logic testReset;
    logic pinA;
    logic pinB;
  } spod_pins_type;

  typedef struct packed {
    logic dataOut;
    logic dataOutEn;
  } spod_tdo_type;

endpackage

// File: hdl/spod_scan_port.sv
// Test-access port with emulator pins and global output-disable logic.
`timescale 1ns/1ps
module spod_scan_port (
  input  wire logic                   core_clk,
  input  wire logic                   reset,
  input  wire logic                   testClk,
  input  wire spod_pkg::spod_pins_type pinsIn,
  input  wire logic                   emuIrqOutA,
  input  wire logic                   emuIrqOutB,
  output logic                        testDataOut,
  output logic                        testDataOutEn,
  output logic                        emulator_pin_a_out,
  output logic                        emulator_pin_a_oe,
  output logic                        emulator_pin_b_or_output_disable_out,
  output logic                        emulator_pin_b_or_output_disable_oe,
  output logic                        emuIrqInA,
  output logic                        emuIrqInB,
  output logic                        scanControl,
  output logic                        outputsDisabled
);
  import spod_pkg::*;

  // ----------------------------------------------------------------
  // Input synchronisers
  // ----------------------------------------------------------------
  logic          clkMeta;
  logic          clkSync;
  logic          clkPrev;
  spod_pins_type pinsMeta;
  spod_pins_type pinsSync;

  // The test clock rests low, so clkPrev resets low and no false edge follows reset.
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      clkMeta  <= 1'b0;
      clkSync  <= 1'b0;
      clkPrev  <= 1'b0;
      pinsMeta <= '0;
      pinsSync <= '0;
    end else begin
      clkMeta  <= testClk;
      clkSync  <= clkMeta;
      clkPrev  <= clkSync;
      pinsMeta <= pinsIn;
      pinsSync <= pinsMeta;
    end
  end

  logic riseEdge;
  logic fallEdge;
  logic scanOn;
  assign riseEdge = clkSync & ~clkPrev;
  assign fallEdge = ~clkSync & clkPrev;
  // Edges are only seen if the test clock is well below core_clk / 4.
  assign scanOn   = pinsSync.testReset;

  // ----------------------------------------------------------------
  // Controller state machine
  // ----------------------------------------------------------------
  spod_state_type state;
  spod_state_type next_state;
  logic           ms;
  assign ms = pinsSync.modeSelect;

  always_comb begin
    unique case (state)
      ST_RESET:      next_state = ms ? ST_RESET : ST_IDLE;
      ST_IDLE:       next_state = ms ? ST_SEL_DR : ST_IDLE;
      ST_SEL_DR:     next_state = ms ? ST_SEL_IR : ST_CAPTURE_DR;
      ST_CAPTURE_DR: next_state = ms ? ST_EXIT1_DR : ST_SHIFT_DR;
      ST_SHIFT_DR:   next_state = ms ? ST_EXIT1_DR : ST_SHIFT_DR;
      ST_EXIT1_DR:   next_state = ms ? ST_UPDATE_DR : ST_PAUSE_DR;
      ST_PAUSE_DR:   next_state = ms ? ST_EXIT2_DR : ST_PAUSE_DR;
      ST_EXIT2_DR:   next_state = ms ? ST_UPDATE_DR : ST_SHIFT_DR;
      ST_UPDATE_DR:  next_state = ms ? ST_SEL_DR : ST_IDLE;
      ST_SEL_IR:     next_state = ms ? ST_RESET : ST_CAPTURE_IR;
      ST_CAPTURE_IR: next_state = ms ? ST_EXIT1_IR : ST_SHIFT_IR;
      ST_SHIFT_IR:   next_state = ms ? ST_EXIT1_IR : ST_SHIFT_IR;
      ST_EXIT1_IR:   next_state = ms ? ST_UPDATE_IR : ST_PAUSE_IR;
      ST_PAUSE_IR:   next_state = ms ? ST_EXIT2_IR : ST_PAUSE_IR;
      ST_EXIT2_IR:   next_state = ms ? ST_UPDATE_IR : ST_SHIFT_IR;
      ST_UPDATE_IR:  next_state = ms ? ST_SEL_DR : ST_IDLE;
    endcase
  end

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      state <= ST_RESET;
    end else if (!scanOn) begin
      state <= ST_RESET;
    end else if (riseEdge) begin
      state <= next_state;
    end
  end

  // ----------------------------------------------------------------
  // Instruction and data registers
  // ----------------------------------------------------------------
  logic [IR_WIDTH-1:0]  irShift;
  logic [IR_WIDTH-1:0]  irActive;
  logic [DIR_WIDTH-1:0] dirShift;
  logic [DIR_WIDTH-1:0] emuDir;
  logic                 bypassBit;
  logic                 dirSelected;
  assign dirSelected = (irActive == INSTR_EMU_DIR);

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      irShift  <= IR_RESET_VALUE;
      irActive <= IR_RESET_VALUE;
    end else if (state == ST_RESET) begin
      irShift  <= IR_RESET_VALUE;
      irActive <= IR_RESET_VALUE;
    end else if (riseEdge) begin
      if (state == ST_CAPTURE_IR) begin
        irShift <= IR_CAPTURE_VALUE;
      end else if (state == ST_SHIFT_IR) begin
        irShift <= {pinsSync.dataIn, irShift[IR_WIDTH-1:1]};
      end else if (state == ST_UPDATE_IR) begin
        irActive <= irShift;
      end
    end
  end

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      dirShift  <= EMU_DIR_RESET;
      emuDir    <= EMU_DIR_RESET;
      bypassBit <= 1'b0;
    end else if (state == ST_RESET) begin
      emuDir    <= EMU_DIR_RESET;
      bypassBit <= 1'b0;
    end else if (riseEdge) begin
      if (state == ST_CAPTURE_DR) begin
        dirShift  <= emuDir;
        bypassBit <= 1'b0;
      end else if (state == ST_SHIFT_DR) begin
        if (dirSelected) begin
          dirShift <= {pinsSync.dataIn, dirShift[DIR_WIDTH-1:1]};
        end else begin
          bypassBit <= pinsSync.dataIn;
        end
      end else if (state == ST_UPDATE_DR && dirSelected) begin
        emuDir <= dirShift;
      end
    end
  end

  // ----------------------------------------------------------------
  // Serial data output, changed on falling edges only
  // ----------------------------------------------------------------
  logic offCond;
  logic inShiftIr;
  logic inShiftDr;
  assign offCond   = ~pinsSync.testReset & pinsSync.pinA & ~pinsSync.pinB;
  assign inShiftIr = (state == ST_SHIFT_IR);
  assign inShiftDr = (state == ST_SHIFT_DR);

  // The enable moves on the same falling edge as the data, so a controller never sees
  // the pin start driving in the middle of a bit.
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      testDataOut   <= 1'b0;
      testDataOutEn <= 1'b0;
    end else if (offCond || !scanOn) begin
      testDataOutEn <= 1'b0;
    end else if (fallEdge) begin
      testDataOutEn <= inShiftIr || inShiftDr;
      if (inShiftIr) begin
        testDataOut <= irShift[0];
      end else if (inShiftDr) begin
        testDataOut <= dirSelected ? dirShift[0] : bypassBit;
      end
    end
  end

  // ----------------------------------------------------------------
  // Emulator pins and output disable
  // ----------------------------------------------------------------
  // Index 0 is pin A and index 1 is pin B, as in the direction register.
  logic [DIR_WIDTH-1:0] pinLevel;
  logic [DIR_WIDTH-1:0] irqOut;
  assign pinLevel = {pinsSync.pinB, pinsSync.pinA};
  assign irqOut   = {emuIrqOutB, emuIrqOutA};

  // One register stage per pin keeps every pin output straight from a flip-flop.
  for (genvar p = 0; p < DIR_WIDTH; p++) begin : gen_emu_pin
    logic drive;
    logic driveEn;
    logic irqSeen;
    always_ff @(posedge core_clk or posedge reset) begin
      if (reset) begin
        drive   <= 1'b0;
        driveEn <= 1'b0;
        irqSeen <= 1'b0;
      end else begin
        drive   <= irqOut[p];
        // In functional mode both pins are inputs so pin B can serve as the disable.
        driveEn <= scanOn & emuDir[p];
        irqSeen <= scanOn & ~emuDir[p] & pinLevel[p];
      end
    end
  end

  assign emulator_pin_a_out                   = gen_emu_pin[DIR_BIT_A].drive;
  assign emulator_pin_a_oe                    = gen_emu_pin[DIR_BIT_A].driveEn;
  assign emulator_pin_b_or_output_disable_out = gen_emu_pin[DIR_BIT_B].drive;
  assign emulator_pin_b_or_output_disable_oe  = gen_emu_pin[DIR_BIT_B].driveEn;
  assign emuIrqInA                            = gen_emu_pin[DIR_BIT_A].irqSeen;
  assign emuIrqInB                            = gen_emu_pin[DIR_BIT_B].irqSeen;

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      scanControl     <= 1'b0;
      outputsDisabled <= 1'b0;
    end else begin
      scanControl     <= scanOn;
      outputsDisabled <= offCond;
    end
  end

endmodule // spod_scan_port

// File: bench/spod_scan_port_chk.sv
// Concurrent checks of the scan port, seen at its top-level ports.
`timescale 1ns/1ps
module spod_scan_port_chk (
  input wire logic                    core_clk,
  input wire logic                    reset,
  input wire logic                    testClk,
  input wire spod_pkg::spod_pins_type pinsIn,
  input wire logic                    emuIrqOutA,
  input wire logic                    emuIrqOutB,
  input wire logic                    testDataOut,
  input wire logic                    testDataOutEn,
  input wire logic                    emulator_pin_a_out,
  input wire logic                    emulator_pin_a_oe,
  input wire logic                    emulator_pin_b_or_output_disable_out,
  input wire logic                    emulator_pin_b_or_output_disable_oe,
  input wire logic                    emuIrqInA,
  input wire logic                    emuIrqInB,
  input wire logic                    scanControl,
  input wire logic                    outputsDisabled
);
  import spod_pkg::*;
  default clocking @(posedge core_clk); endclocking
  default disable iff (reset);
  wire logic scanOff = !pinsIn.testReset;
  wire logic offCond = scanOff && pinsIn.pinA && !pinsIn.pinB;
  wire logic anyOe = emulator_pin_a_oe || emulator_pin_b_or_output_disable_oe;
  AST_DIS_COND: assert property (outputsDisabled == $past(offCond, 3))
    else $error("output disable does not follow its condition");
  AST_SCAN_CTL: assert property (scanControl == $past(pinsIn.testReset, 3))
    else $error("scan control does not follow test reset");
  AST_TDO_IDLE: assert property (scanOff [*5] |-> !testDataOutEn)
    else $error("data output driven in functional mode");
  AST_DIS_FLOAT: assert property (outputsDisabled [*2] |-> !anyOe && !testDataOutEn)
    else $error("a driver stays on while outputs are disabled");
  AST_PIN_B_IN: assert property (scanOff [*5] |-> !anyOe)
    else $error("emulator pin driven in functional mode");
  AST_TDO_FALL: assert property ($changed(testDataOut) |-> !$past(testClk, 2))
    else $error("data output changed away from a falling edge");
  AST_EN_FALL: assert property ($rose(testDataOutEn) |-> !$past(testClk, 2))
    else $error("data output enabled away from a falling edge");
  AST_PIN_A_DRV: assert property ($stable(emuIrqOutA) [*4] ##0 emulator_pin_a_oe
    |-> emulator_pin_a_out == emuIrqOutA)
    else $error("pin A does not carry the core interrupt level");
  cover property ($rose(outputsDisabled));
  cover property ($rose(testDataOutEn));
  cover property ($rose(emulator_pin_a_oe));
endmodule // spod_scan_port_chk

bind spod_scan_port spod_scan_port_chk u_chk (
  .core_clk                             (core_clk),
  .reset                                (reset),
  .testClk                              (testClk),
  .pinsIn                               (pinsIn),
  .emuIrqOutA                           (emuIrqOutA),
  .emuIrqOutB                           (emuIrqOutB),
  .testDataOut                          (testDataOut),
  .testDataOutEn                        (testDataOutEn),
  .emulator_pin_a_out                   (emulator_pin_a_out),
  .emulator_pin_a_oe                    (emulator_pin_a_oe),
  .emulator_pin_b_or_output_disable_out (emulator_pin_b_or_output_disable_out),
  .emulator_pin_b_or_output_disable_oe  (emulator_pin_b_or_output_disable_oe),
  .emuIrqInA                            (emuIrqInA),
  .emuIrqInB                            (emuIrqInB),
  .scanControl                          (scanControl),
  .outputsDisabled                      (outputsDisabled)
);

// File: bench/spod_jtag_host.sv
// Model of the external scan controller that drives the test-access port.
`timescale 1ns/1ps
module spod_jtag_host (
  output logic      testClk,
  output logic      modeSelect,
  output logic      dataIn,
  input  wire logic dataOut
);
  import spod_pkg::*;
  // The test clock stands low between frames; inputs rest at their pull-up level.
  initial begin
    testClk = 1'b0;
    modeSelect = 1'b1;
    dataIn = 1'b1;
  end
  // Inputs change at the fall, so they settle a half period before the rise.
  task automatic step(input logic ms, input logic di, output logic so);
    modeSelect = ms;
    dataIn = di;
    #24;
    so = dataOut;
    testClk = 1'b1;
    #24;
    testClk = 1'b0;
  endtask
  // Every walk that opens a scan starts with one low mode-select bit, which parks the controller in idle
  // whether it starts from idle or from the reset state.
  task automatic walk(input logic [7:0] seq, input int n);
    logic so;
    for (int i = 0; i < n; i++) begin
      step(seq[i], 1'b1, so);
    end
  endtask
  task automatic scan_ir(input logic [3:0] din, output logic [3:0] dout);
    walk(8'h06, 5);
    for (int i = 0; i < 4; i++) begin
      step(i == 3, din[i], dout[i]);
    end
    walk(8'h01, 2);
  endtask
  task automatic scan_dr(input logic [1:0] din, output logic [1:0] dout);
    walk(8'h02, 4);
    for (int i = 0; i < 2; i++) begin
      step(i == 1, din[i], dout[i]);
    end
    walk(8'h01, 2);
  endtask
endmodule // spod_jtag_host

// File: bench/spod_scan_port_tb.sv
// Self-checking testbench of the scan port and output-disable block.
`timescale 1ns/1ps
module spod_scan_port_tb;
  import spod_pkg::*;
  logic          core_clk, reset, testClk, emuIrqOutA, emuIrqOutB, trst, drvA, drvB, ms, di;
  logic          testDataOut, testDataOutEn, emuIrqInA, emuIrqInB, scanControl, outputsDisabled;
  logic          emulator_pin_a_out, emulator_pin_a_oe;
  logic          emulator_pin_b_or_output_disable_out, emulator_pin_b_or_output_disable_oe;
  logic [3:0]    got;
  logic [1:0]    dir;
  int            err_count, samples_checked, cycles;
  spod_pins_type pinsIn;
  // A released pin shows what the board drives; pin B rests high on its pull-up.
  wire pinA = emulator_pin_a_oe ? emulator_pin_a_out : drvA;
  wire pinB = emulator_pin_b_or_output_disable_oe ?
              emulator_pin_b_or_output_disable_out : drvB;
  wire tdoWire = testDataOutEn ? testDataOut : 1'bz;
  assign pinsIn = {ms, di, trst, pinA, pinB};
  spod_scan_port dut (
    .core_clk                             (core_clk),
    .reset                                (reset),
    .testClk                              (testClk),
    .pinsIn                               (pinsIn),
    .emuIrqOutA                           (emuIrqOutA),
    .emuIrqOutB                           (emuIrqOutB),
    .testDataOut                          (testDataOut),
    .testDataOutEn                        (testDataOutEn),
    .emulator_pin_a_out                   (emulator_pin_a_out),
    .emulator_pin_a_oe                    (emulator_pin_a_oe),
    .emulator_pin_b_or_output_disable_out (emulator_pin_b_or_output_disable_out),
    .emulator_pin_b_or_output_disable_oe  (emulator_pin_b_or_output_disable_oe),
    .emuIrqInA                            (emuIrqInA),
    .emuIrqInB                            (emuIrqInB),
    .scanControl                          (scanControl),
    .outputsDisabled                      (outputsDisabled)
  );
  spod_jtag_host host (.testClk(testClk), .modeSelect(ms), .dataIn(di), .dataOut(tdoWire));
  initial begin
    core_clk = 1'b0;
    forever #2.5 core_clk = ~core_clk;
  end
  task automatic chk(input string what, input logic [3:0] exp, input logic [3:0] seen);
    samples_checked++;
    if (seen !== exp) begin
      err_count++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic tally_and_finish();
    if (err_count == 0 && samples_checked > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  // The odd offset keeps link edges off the core clock's edges.
  task automatic wait_clk(input int n);
    repeat (n) @(posedge core_clk);
    #1.2;
  endtask
  task automatic t_ir_capture();
    chk("scan control", 4'h1, {3'h0, scanControl});
    chk("idle enable", 4'h0, {3'h0, testDataOutEn});
    host.scan_ir(INSTR_EMU_DIR, got);
    chk("ir capture", IR_CAPTURE_VALUE, got);
  endtask
  task automatic t_pin_dir();
    wait_clk(1);
    emuIrqOutA = 1'b1;
    host.scan_dr(2'h3, dir);
    chk("dir capture", {2'h0, EMU_DIR_RESET}, {2'h0, dir});
    wait_clk(6);
    chk("pin a drive", 4'h1, {3'h0, pinA});
    chk("pin b drive", 4'h0, {3'h0, pinB});
    host.scan_dr(2'h1, dir);
    wait_clk(1);
    emuIrqOutA = 1'b0;
    wait_clk(6);
    chk("dir readback", 4'h3, {2'h0, dir});
    chk("pin a follow", 4'h0, {3'h0, pinA});
    chk("pin b input", 4'h1, {3'h0, emuIrqInB});
  endtask
  task automatic t_bypass();
    host.scan_ir(IR_RESET_VALUE, got);
    host.scan_dr(2'h1, dir);
    chk("bypass path", 4'h2, {2'h0, dir});
  endtask
  task automatic t_disable();
    wait_clk(1);
    trst = 1'b0;
    drvA = 1'b1;
    drvB = 1'b0;
    wait_clk(6);
    chk("disable on", 4'h1, {3'h0, outputsDisabled});
    chk("scan released", 4'h0, {3'h0, scanControl});
    chk("pin a float", 4'h0, {3'h0, emulator_pin_a_oe});
    chk("tdo float", 4'h0, {3'h0, testDataOutEn});
    host.scan_ir(INSTR_EMU_DIR, got);
    chk("ignored scan", 4'hZ, got);
    wait_clk(1);
    drvA = 1'b0;
    wait_clk(6);
    chk("disable off", 4'h0, {3'h0, outputsDisabled});
    trst = 1'b1;
    drvA = 1'b1;
    drvB = 1'b1;
    wait_clk(6);
    chk("scan regained", 4'h1, {3'h0, scanControl});
    chk("pin a input", 4'h1, {3'h0, emuIrqInA});
  endtask
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 20000) begin
      err_count++;
      tally_and_finish();
    end
  end
  initial begin
    reset = 1'b1;
    trst = 1'b0;
    emuIrqOutA = 1'b0;
    emuIrqOutB = 1'b0;
    drvA = 1'b0;
    drvB = 1'b1;
    err_count = 0;
    samples_checked = 0;
    cycles = 0;
    wait_clk(6);
    reset = 1'b0;
    trst = 1'b1;
    wait_clk(6);
    t_ir_capture();
    t_pin_dir();
    t_bypass();
    t_disable();
    tally_and_finish();
  end
endmodule // spod_scan_port_tb
